/* bench/status_trigger_selftest_ctl_tb.sv */
// self-checking bench for the status, trigger and self-test controller
`default_nettype none
module status_trigger_selftest_ctl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] v;
    logic [7:0]  ev;
  } stc_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, trigger_pulse, er;
  logic [7:0]  paddr, status_events, subtest_fail;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] volt_lvl, curr_lvl;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;
  int          pulses = 0;
  stc_row_t rows [31] = '{
    '{1'h1, stc_pkg::A_SRE, 32'hFF, 8'h00},
    '{1'h0, stc_pkg::A_SRE, 32'hBF, 8'h00},
    '{1'h0, stc_pkg::A_STB, 32'h00, 8'h00},
    '{1'h1, stc_pkg::A_TVOLT, 32'h1234, 8'h21},
    '{1'h0, stc_pkg::A_STB, 32'h61, 8'h21},
    '{1'h0, stc_pkg::A_SPOLL, 32'h61, 8'h21},
    '{1'h0, stc_pkg::A_SPOLL, 32'h21, 8'h21},
    '{1'h0, stc_pkg::A_STB, 32'h61, 8'h21},
    '{1'h1, stc_pkg::A_TCURR, 32'h0567, 8'h21},
    '{1'h1, stc_pkg::A_CTRL, 32'h0E, 8'h21},
    '{1'h1, stc_pkg::A_CMD, 32'h1, 8'h21},
    '{1'h0, stc_pkg::A_AVOLT, 32'h0, 8'h21},
    '{1'h1, stc_pkg::A_CMD, 32'h3, 8'h21},
    '{1'h0, stc_pkg::A_OPCON, 32'h21, 8'h21},
    '{1'h1, stc_pkg::A_CMD, 32'h1, 8'h21},
    '{1'h0, stc_pkg::A_AVOLT, 32'h1234, 8'h21},
    '{1'h0, stc_pkg::A_ACURR, 32'h0567, 8'h21},
    '{1'h0, stc_pkg::A_OPCON, 32'h08, 8'h21},
    '{1'h1, stc_pkg::A_TVOLT, 32'h2222, 8'h21},
    '{1'h1, stc_pkg::A_CMD, 32'h1, 8'h21},
    '{1'h0, stc_pkg::A_AVOLT, 32'h1234, 8'h21},
    '{1'h1, stc_pkg::A_CTRL, 32'h0F, 8'h21},
    '{1'h1, stc_pkg::A_CMD, 32'h1, 8'h21},
    '{1'h0, stc_pkg::A_AVOLT, 32'h2222, 8'h21},
    '{1'h0, stc_pkg::A_OPCON, 32'h29, 8'h21},
    '{1'h1, stc_pkg::A_TVOLT, 32'h3333, 8'h21},
    '{1'h1, stc_pkg::A_CTRL, 32'h07, 8'h21},
    '{1'h1, stc_pkg::A_CMD, 32'h2, 8'h21},
    '{1'h1, stc_pkg::A_CTRL, 32'h0B, 8'h21},
    '{1'h1, stc_pkg::A_CMD, 32'h1, 8'h21},
    '{1'h0, 8'h30, 32'h0, 8'h21}
  };
  stc_ctl i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .status_events(status_events),
    .subtest_fail(subtest_fail), .active_voltage_level(volt_lvl), .active_current_level(curr_lvl),
    .trigger_pulse(trigger_pulse)
  );
  stc_host i_host (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  // ==========
  // clock, timeout and helpers
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (trigger_pulse === 1'h1) pulses <= pulses + 1;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk(input string name, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, x, g);
    end
  endtask
  task automatic io(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(w, a, d, rd, er);
  endtask
  task automatic selftest(input logic [3:0] c, input logic [7:0] f, input logic [31:0] x);
    subtest_fail <= f;
    io(1'h1, stc_pkg::A_CMD, {28'h0, c});
    rd = 32'h0;
    for (int n = 0; n < 40 && rd[stc_pkg::TR_VALID] !== 1'h1; n++) io(1'h0, stc_pkg::A_TRES, 32'h0);
    chk("test result", x, rd);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========
  // sequence
  initial begin
    presetn       = 1'h0;
    status_events = 8'h00;
    subtest_fail  = 8'h00;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    foreach (rows[i]) begin
      status_events <= rows[i].ev;
      io(rows[i].w, rows[i].a, rows[i].v);
      if (!rows[i].w) chk("read data", rows[i].v, rd);
      chk("error flag", {31'h0, rows[i].a > stc_pkg::A_TRES}, {31'h0, er});
    end
    io(1'h1, stc_pkg::A_CTRL, 32'h0F);
    io(1'h1, stc_pkg::A_CMD, 32'h2);
    io(1'h0, stc_pkg::A_AVOLT, 32'h0);
    chk("group trigger level", 32'h3333, rd);
    chk("voltage pin", 32'h3333, {16'h0, volt_lvl});
    chk("current pin", 32'h0567, {16'h0, curr_lvl});
    chk("trigger count", 32'h3, pulses);
    io(1'h1, stc_pkg::A_TVOLT, 32'h4444);
    io(1'h1, stc_pkg::A_CTRL, 32'h0E);
    io(1'h1, stc_pkg::A_CMD, {28'h0, stc_pkg::C_INIT});
    io(1'h1, stc_pkg::A_CMD, {28'h0, stc_pkg::C_ABORT});
    io(1'h1, stc_pkg::A_CMD, {28'h0, stc_pkg::C_TRG});
    io(1'h0, stc_pkg::A_AVOLT, 32'h0);
    chk("level after abort", 32'h3333, rd);
    chk("pulses after abort", 32'h3, pulses);
    $display("register table done");
    selftest(stc_pkg::C_TST, 8'hFF, 32'h117);
    selftest(stc_pkg::C_DIAG, 8'hFF, 32'h1F7);
    selftest(stc_pkg::C_TST, 8'hE8, 32'h100);
    subtest_fail <= 8'h24;
    io(1'h1, stc_pkg::A_CMD, {28'h0, stc_pkg::C_DIAG});
    io(1'h1, stc_pkg::A_CMD, {28'h0, stc_pkg::C_WAI});
    io(1'h1, stc_pkg::A_CMD, {28'h0, stc_pkg::C_ABORT});
    io(1'h0, stc_pkg::A_TRES, 32'h0);
    chk("result after wait", 32'h124, rd);
    $display("self test done");
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    io(1'h0, stc_pkg::A_AVOLT, 32'h0);
    chk("level after reset", 32'h0, rd);
    chk("voltage pin after reset", 32'h0, {16'h0, volt_lvl});
    $display("reset test done");
    end_sim();
  end
endmodule
`default_nettype wire

/* bench/stc_ctl_chk.sv */
// port-level assertions for the status, trigger and self-test controller
`default_nettype none
module stc_ctl_chk #(
  parameter int LVL_W = 16
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [7:0]       status_events,
  input wire logic [7:0]       subtest_fail,
  input wire logic [LVL_W-1:0] active_voltage_level,
  input wire logic [LVL_W-1:0] active_current_level,
  input wire logic             trigger_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // mirror of the control bits
  logic       rd_setup;
  logic       cmd_wr;
  logic       fire_ok;
  logic [3:0] ctrl_q;
  assign rd_setup = psel && !penable && !pwrite;
  assign cmd_wr   = psel && penable && pready && pwrite && paddr == stc_pkg::A_CMD;
  assign fire_ok  = cmd_wr && (pwdata[3:0] == stc_pkg::C_TRG || pwdata[3:0] == stc_pkg::C_GET)
                    && ctrl_q[stc_pkg::CB_OUT] && ctrl_q[stc_pkg::CB_LSN] && ctrl_q[stc_pkg::CB_BUS];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 4'h0;
    end else if (psel && penable && pready && pwrite && paddr == stc_pkg::A_CTRL) begin
      ctrl_q <= pwdata[3:0];
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  mask_read_a: assert property (
    rd_setup && paddr == stc_pkg::A_SRE |=> prdata[6] == 1'h0 && prdata[31:8] == 24'h0)
    else $error("mask read shows bit 6");
  stb_read_a: assert property (
    rd_setup && paddr == stc_pkg::A_STB && status_events == $past(status_events)
    |=> (prdata[7:0] & 8'hBF) == (status_events & 8'hBF))
    else $error("status byte differs from conditions");
  stall_cmd_a: assert property (
    !pready |-> psel && pwrite && paddr == stc_pkg::A_CMD)
    else $error("stall outside a command write");
  level_load_a: assert property (
    $changed(active_voltage_level) || $changed(active_current_level) |-> ##[0:2] trigger_pulse)
    else $error("levels moved without a trigger");
  trig_gate_a: assert property (
    trigger_pulse |-> $past(fire_ok) || $past(fire_ok, 2) || $past(fire_ok, 3))
    else $error("trigger without a gated command");
  trig_once_a: assert property (
    trigger_pulse |=> !trigger_pulse)
    else $error("trigger pulse too long");
  test_code_a: assert property (
    rd_setup && paddr == stc_pkg::A_TRES
    |=> (prdata[7:0] & ~stc_pkg::TST_EXT) == 8'h0 && prdata[31:9] == 23'h0)
    else $error("test code has an unused bit");
  cont_armed_a: assert property (
    rd_setup && paddr == stc_pkg::A_OPCON && $past(ctrl_q[stc_pkg::CB_CONT], 2) && ctrl_q[stc_pkg::CB_BUS]
    && !$past(cmd_wr) |=> prdata[stc_pkg::OC_WAIT] && prdata[stc_pkg::OC_ARMED])
    else $error("continuous mode not armed");
endmodule

bind stc_ctl stc_ctl_chk #(.LVL_W(LVL_W)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .status_events(status_events),
  .subtest_fail(subtest_fail), .active_voltage_level(active_voltage_level),
  .active_current_level(active_current_level), .trigger_pulse(trigger_pulse)
);
`default_nettype wire

/* bench/stc_host.sv */
// remote controller model issuing register transfers
`default_nettype none
module stc_host (
  input  wire logic        pclk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // ==========
  // one transfer: setup, then access until ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule
`default_nettype wire

/* common/stc_pkg.sv */
// constants for the status, trigger and self-test controller
`default_nettype none
package stc_pkg;
  localparam int unsigned CLK_MHZ    = 10;
  localparam int unsigned SETTLE_NS  = 2000;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STEP_NS    = 500;
  localparam int unsigned STEP_CYC   = (STEP_NS * CLK_MHZ + 999) / 1000;

  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_SRE   = 8'h04;
  localparam logic [7:0] A_STB   = 8'h08;
  localparam logic [7:0] A_SPOLL = 8'h0C;
  localparam logic [7:0] A_CMD   = 8'h10;
  localparam logic [7:0] A_TVOLT = 8'h14;
  localparam logic [7:0] A_TCURR = 8'h18;
  localparam logic [7:0] A_AVOLT = 8'h1C;
  localparam logic [7:0] A_ACURR = 8'h20;
  localparam logic [7:0] A_OPCON = 8'h24;
  localparam logic [7:0] A_TRES  = 8'h28;

  localparam logic [3:0] C_TRG   = 4'h1;
  localparam logic [3:0] C_GET   = 4'h2;
  localparam logic [3:0] C_INIT  = 4'h3;
  localparam logic [3:0] C_ABORT = 4'h4;
  localparam logic [3:0] C_TST   = 4'h5;
  localparam logic [3:0] C_DIAG  = 4'h6;
  localparam logic [3:0] C_WAI   = 4'h7;

  localparam int CB_CONT = 0;
  localparam int CB_BUS  = 1;
  localparam int CB_OUT  = 2;
  localparam int CB_LSN  = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;

  localparam int SB_SUM = 6;
  localparam int OC_ARMED = 0;
  localparam int OC_TST   = 1;
  localparam int OC_HOLD  = 2;
  localparam int OC_SETL  = 3;
  localparam int OC_WAIT  = 5;
  localparam int TR_VALID = 8;

  localparam logic [7:0] TST_BASIC = 8'h17;
  localparam logic [7:0] TST_EXT   = 8'hF7;
  localparam logic [2:0] TST_LAST  = 3'h7;

  typedef enum logic [1:0] {
    STC_IDLE = 2'b00,
    STC_RUN  = 2'b01,
    STC_DONE = 2'b11
  } stc_tst_state_t;
endpackage
`default_nettype wire

/* common/stc_tst_if.sv */
// interface between the controller and its self-test engine
`default_nettype none
interface stc_tst_if;
  logic       start;
  logic       extended;
  logic       busy;
  logic       done;
  logic [7:0] code;
  modport ctl (output start, output extended, input busy, input done, input code);
  modport eng (input start, input extended, output busy, output done, output code);
endinterface
`default_nettype wire

/* hdl/stc_ctl.sv */
// status byte, bus trigger, self-test and wait-to-continue controller
// How it works
// [RQ1] enable-mask query returns the 8-bit service-request enable mask
// [RQ2] status-byte read returns byte with summary in bit 6, clears nothing
// [RQ3] status bits clear only when their source conditions clear
// [RQ4] summary flag set while any enabled service reason is present
// [RQ5] serial poll shows request flag in bit 6, then clears it
// [RQ6] bus trigger fires only when armed, source bus, waiting flag set
// [RQ7] continuous initiation keeps the trigger armed
// [RQ8] without continuous mode, each initiate arms exactly one trigger
// [RQ9] trigger while unarmed is dropped silently, no error
// [RQ10] trigger loads preset levels into active outputs, clears waiting flag
// [RQ11] continuous mode re-arms at once and sets waiting flag again
// [RQ12] trigger and group trigger act only while addressed as listener
// [RQ13] output off means bus triggers are ignored
// [RQ14] self-test returns zero on pass, else failure code up to 128; the code here can reach 0xF7 (247) from the extended query
// [RQ15] all subtests run even after a failure, bits combine
// [RQ16] basic code bits: 0 program, 1 working, 2 store, 4 analog link
// [RQ17] bits 5 to 7 only from the extended diagnostic query
// [RQ18] after wait-to-continue, later commands held until earlier ones finish
// [RQ19] wait completes once commands done and output levels settled
// [RQ20] bit 6 set whenever status byte AND enable mask is nonzero
// [RQ21] enable mask bit 6 cannot be written
// [RQ22] self-test result posted only after all subtests finish
`default_nettype none
module stc_ctl #(
  parameter int LVL_W = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output var  logic [31:0]      prdata,
  output logic                  pready,
  output var  logic             pslverr,
  input  wire logic [7:0]       status_events,
  input  wire logic [7:0]       subtest_fail,
  output var  logic [LVL_W-1:0] active_voltage_level,
  output var  logic [LVL_W-1:0] active_current_level,
  output var  logic             trigger_pulse
);
  stc_tst_if tif ();

  logic [3:0]       ctrl_reg;
  logic [7:0]       sre_reg;
  logic [LVL_W-1:0] trig_volt_reg;
  logic [LVL_W-1:0] triggered_current_level;
  logic             armed_reg;
  logic             waiting_for_trigger_flag;
  logic             rqs_reg;
  logic             mss_d_reg;
  logic             hold_reg;
  logic             start_reg;
  logic             ext_reg;
  logic [8:0]       tres_reg;
  logic [15:0]      settle_reg;

  logic       acc_wr;
  logic       acc_rd;
  logic       setup;
  logic       cmd_go;
  logic [3:0] cmd;
  logic       trg_cmd;
  logic       fire;
  logic       mss;
  logic [7:0] stb;
  logic [7:0] spoll;
  logic       pending;
  logic       cont;

  // =========================================
  // apb handshake
  // later command writes stall while a wait is open (see [RQ18])
  assign pready = !(psel && pwrite && (paddr == stc_pkg::A_CMD) && hold_reg);
  assign setup  = psel && !penable;
  assign acc_wr = psel && penable && pwrite && pready;
  assign acc_rd = psel && penable && !pwrite && pready;
  assign cmd_go = acc_wr && (paddr == stc_pkg::A_CMD);
  assign cmd    = pwdata[3:0];
  assign cont   = ctrl_reg[stc_pkg::CB_CONT];

  // =========================================
  // status byte
  // summary from enabled events, bit 6 itself excluded (see [RQ20])
  assign mss = |(status_events & sre_reg);

  always_comb begin
    // summary reflects live reasons, no latching (see [RQ4])
    stb = status_events;
    stb[stc_pkg::SB_SUM] = mss;
    // poll view carries the request flag instead (see [RQ5])
    spoll = status_events;
    spoll[stc_pkg::SB_SUM] = rqs_reg;
  end

  // request flag raised on a new summary, cleared by a poll read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mss_d_reg <= 1'b0;
      rqs_reg   <= 1'b0;
    end else begin
      mss_d_reg <= mss;
      if (mss && !mss_d_reg) begin
        rqs_reg <= 1'b1;
      end else if (acc_rd && (paddr == stc_pkg::A_SPOLL)) begin
        rqs_reg <= 1'b0; // see [RQ5]
      end
    end
  end

  // =========================================
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg                <= stc_pkg::CTRL_RST;
      sre_reg                 <= 8'h00;
      trig_volt_reg           <= '0;
      triggered_current_level <= '0;
    end else if (acc_wr) begin
      if (paddr == stc_pkg::A_CTRL) begin
        ctrl_reg <= pwdata[3:0];
      end else if (paddr == stc_pkg::A_SRE) begin
        sre_reg <= pwdata[7:0];
        sre_reg[stc_pkg::SB_SUM] <= 1'b0; // see [RQ21]
      end else if (paddr == stc_pkg::A_TVOLT) begin
        trig_volt_reg <= pwdata[LVL_W-1:0];
      end else if (paddr == stc_pkg::A_TCURR) begin
        triggered_current_level <= pwdata[LVL_W-1:0];
      end
    end
  end

  // =========================================
  // trigger system
  // only listener-addressed triggers count (see [RQ12])
  assign trg_cmd = cmd_go && ((cmd == stc_pkg::C_TRG) || (cmd == stc_pkg::C_GET))
                   && ctrl_reg[stc_pkg::CB_LSN];
  // output off or unarmed: dropped, nothing logged (see [RQ13]) (see [RQ9])
  assign fire = trg_cmd && ctrl_reg[stc_pkg::CB_OUT] && armed_reg
                && ctrl_reg[stc_pkg::CB_BUS] && waiting_for_trigger_flag; // see [RQ6]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg                <= 1'b0;
      waiting_for_trigger_flag <= 1'b0;
    end else begin
      if (cont) begin
        // continuous: always armed, waiting re-set after fire (see [RQ7]) (see [RQ11])
        armed_reg                <= 1'b1;
        waiting_for_trigger_flag <= 1'b1;
      end else if (cmd_go && (cmd == stc_pkg::C_INIT)) begin
        armed_reg                <= 1'b1; // see [RQ8]
        waiting_for_trigger_flag <= 1'b1;
      end else if (fire || (cmd_go && (cmd == stc_pkg::C_ABORT))) begin
        // single shot consumed (see [RQ8]) (see [RQ10])
        armed_reg                <= 1'b0;
        waiting_for_trigger_flag <= 1'b0;
      end else if (acc_wr && (paddr == stc_pkg::A_CTRL) && !pwdata[stc_pkg::CB_CONT]
                   && !armed_reg) begin
        waiting_for_trigger_flag <= 1'b0;
      end
    end
  end

  // active levels follow the presets on each trigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_voltage_level <= '0;
      active_current_level <= '0;
      trigger_pulse        <= 1'b0;
    end else begin
      trigger_pulse <= fire;
      if (fire) begin
        active_voltage_level <= trig_volt_reg; // see [RQ10]
        active_current_level <= triggered_current_level;
      end
    end
  end

  // output settling after a level change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_reg <= 16'h0000;
    end else if (fire) begin
      settle_reg <= 16'(stc_pkg::SETTLE_CYC);
    end else if (settle_reg != 16'h0000) begin
      settle_reg <= settle_reg - 16'h0001;
    end
  end

  // =========================================
  // self test
  assign tif.start    = start_reg;
  assign tif.extended = ext_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg <= 1'b0;
      ext_reg   <= 1'b0;
      tres_reg  <= 9'h000;
    end else begin
      start_reg <= 1'b0;
      if (tif.done) begin
        // combined code, zero on pass (see [RQ14]) (see [RQ16])
        tres_reg <= {1'b1, tif.code};
      end else if (cmd_go && !tif.busy && !start_reg
                   && ((cmd == stc_pkg::C_TST) || (cmd == stc_pkg::C_DIAG))) begin
        start_reg <= 1'b1;
        ext_reg   <= (cmd == stc_pkg::C_DIAG); // see [RQ17]
        tres_reg  <= 9'h000; // see [RQ22]
      end
    end
  end

  stc_selftest u_selftest (
    .pclk         (pclk),
    .presetn      (presetn),
    .subtest_fail (subtest_fail),
    .t            (tif.eng)
  );

  // =========================================
  // wait-to-continue
  assign pending = (settle_reg != 16'h0000) || tif.busy || start_reg || tif.done || fire;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= 1'b0;
    end else if (cmd_go && (cmd == stc_pkg::C_WAI)) begin
      hold_reg <= 1'b1; // see [RQ18]
    end else if (!pending) begin
      hold_reg <= 1'b0; // see [RQ19]
    end
  end

  // =========================================
  // read data, latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      if (paddr == stc_pkg::A_CTRL) begin
        prdata[3:0] <= ctrl_reg;
      end else if (paddr == stc_pkg::A_SRE) begin
        prdata[7:0] <= sre_reg; // see [RQ1]
      end else if (paddr == stc_pkg::A_STB) begin
        prdata[7:0] <= stb; // see [RQ2] (see [RQ3])
      end else if (paddr == stc_pkg::A_SPOLL) begin
        prdata[7:0] <= spoll;
      end else if (paddr == stc_pkg::A_CMD) begin
        prdata[3:0] <= 4'h0;
      end else if (paddr == stc_pkg::A_TVOLT) begin
        prdata[LVL_W-1:0] <= trig_volt_reg;
      end else if (paddr == stc_pkg::A_TCURR) begin
        prdata[LVL_W-1:0] <= triggered_current_level;
      end else if (paddr == stc_pkg::A_AVOLT) begin
        prdata[LVL_W-1:0] <= active_voltage_level;
      end else if (paddr == stc_pkg::A_ACURR) begin
        prdata[LVL_W-1:0] <= active_current_level;
      end else if (paddr == stc_pkg::A_OPCON) begin
        prdata[stc_pkg::OC_ARMED] <= armed_reg;
        prdata[stc_pkg::OC_TST]   <= tif.busy || start_reg;
        prdata[stc_pkg::OC_HOLD]  <= hold_reg;
        prdata[stc_pkg::OC_SETL]  <= (settle_reg != 16'h0000);
        prdata[stc_pkg::OC_WAIT]  <= waiting_for_trigger_flag; // see [RQ6]
      end else if (paddr == stc_pkg::A_TRES) begin
        prdata[8:0] <= tres_reg; // see [RQ14]
      end else begin
        pslverr <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* hdl/stc_selftest.sv */
// self-test engine: walks every subtest and combines failure bits
`default_nettype none
module stc_selftest (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] subtest_fail,
  stc_tst_if.eng          t
);
  stc_pkg::stc_tst_state_t state_reg;
  logic [2:0]  idx_reg;
  logic [15:0] cnt_reg;
  logic [7:0]  acc_reg;
  logic [7:0]  mask_reg;
  logic        step_end;

  assign step_end = (cnt_reg == 16'(stc_pkg::STEP_CYC - 1));
  assign t.busy   = (state_reg == stc_pkg::STC_RUN);
  assign t.done   = (state_reg == stc_pkg::STC_DONE);
  assign t.code   = acc_reg;

  // =========================================
  // subtest sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= stc_pkg::STC_IDLE;
      idx_reg   <= 3'h0;
      cnt_reg   <= 16'h0000;
      acc_reg   <= 8'h00;
      mask_reg  <= 8'h00;
    end else begin
      case (state_reg)
        stc_pkg::STC_RUN: begin
          cnt_reg <= step_end ? 16'h0000 : cnt_reg + 16'h0001;
          if (step_end) begin
            // a failure never stops the walk (see [RQ15])
            acc_reg[idx_reg] <= acc_reg[idx_reg] | (mask_reg[idx_reg] & subtest_fail[idx_reg]);
            idx_reg <= idx_reg + 3'h1;
            if (idx_reg == stc_pkg::TST_LAST) begin
              state_reg <= stc_pkg::STC_DONE;
            end
          end
        end
        stc_pkg::STC_DONE: begin
          // result leaves only once every subtest is over (see [RQ22])
          state_reg <= stc_pkg::STC_IDLE;
        end
        default: begin
          if (t.start) begin
            // extended tests only on the diagnostic query (see [RQ17])
            mask_reg  <= t.extended ? stc_pkg::TST_EXT : stc_pkg::TST_BASIC;
            acc_reg   <= 8'h00;
            idx_reg   <= 3'h0;
            cnt_reg   <= 16'h0000;
            state_reg <= stc_pkg::STC_RUN;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire
